// >>> rtl/bms_selector.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Debug line low: straps pick the mode
// - Pin start writes valid key and code
// - Bad debug key or code means wait
// - Debug selection word decode table
// - Debug line high: stored selection wins
// - Stored selection survives resets until power cycle
// - Wait mode records code, then holds
// - Serial load records code, awaits data
// - Programmable choice via straps or debug
// - Programmed key invalid means flash jump
// - Programmed selection word decode table
// - Unexpected programmed words fall to flash
// - RAM jump only by debug start
// - Flash jump goes below password block
// - SPI standalone via programmable choice or debug selection code 4
// - I2C standalone via programmable choice or debug selection code 5
// - I2C load targets device address 50h

module bms_selector
  import bms_pkg::*;
(
  // Clock and resets
  input wire logic clk,
  input wire logic rst_b,
  input wire logic por_b,
  // Strap and debug pins
  input wire logic strap_pin_low,
  input wire logic strap_pin_high,
  input wire logic debug_reset_line,
  // Programmed memory words
  input wire logic [15:0] programmed_boot_key,
  input wire logic [15:0] programmed_boot_selection,
  // Register port
  input wire logic [bms_pkg::BMS_AW-1:0] reg_addr,
  input wire logic [bms_pkg::BMS_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [bms_pkg::BMS_DW-1:0] reg_rdata,
  // Start outcome
  output bms_pkg::bms_mode_t boot_mode,
  output logic boot_done,
  output logic boot_from_pins,
  output logic jump_en,
  output logic [bms_pkg::BMS_AW-1:0] jump_addr,
  output logic uart_wait,
  output logic wait_hold,
  output logic [6:0] i2c_dev_addr,
  output logic emu_attached
);

  import bms_pkg::*;

  // ****************************************************
  // Reset merge
  // ****************************************************

  // Any reset restarts selection; only power-on clears words
  logic sys_rst_b;
  assign sys_rst_b = rst_b & por_b;

  // ****************************************************
  // Pin synchronisers
  // ****************************************************

  logic [2:0] pin_s; // {debug, high strap, low strap}
  logic dbg_s; // Debug line, synchronised
  logic [1:0] strap_s; // Strap code, high pin first

  // Pins are asynchronous to clk
  bms_sync2 #(
    .W(3)
  ) u_sync (
    .clk(clk),
    .rst_b(sys_rst_b),
    .d({debug_reset_line, strap_pin_high, strap_pin_low}),
    .q(pin_s)
  );

  assign dbg_s = pin_s[2];
  assign strap_s = pin_s[1:0];

  // ****************************************************
  // Selection sequencer
  // ****************************************************

  typedef enum logic [1:0] {
    ST_SETTLE, ST_EVAL, ST_STORE, ST_DONE
  } bms_state_t;

  bms_state_t st_q; // Sequencer state
  bms_state_t st_d;
  logic [1:0] settle_q; // Cycles since release
  logic [1:0] settle_d;

  // Walk once per release, then park
  always_comb
  begin
    st_d = st_q;
    settle_d = settle_q;
    unique case (st_q)
      ST_SETTLE:
      begin
        // Let the synchroniser fill with real pin levels
        if (settle_q == BMS_SETTLE_CYC - 2'h1)
          st_d = ST_EVAL;
        else
          settle_d = settle_q + 2'h1;
      end
      ST_EVAL:
        st_d = ST_STORE;
      ST_STORE:
        st_d = ST_DONE;
      ST_DONE:
        st_d = ST_DONE;
    endcase
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!sys_rst_b)
    begin
      st_q <= ST_SETTLE;
      settle_q <= 2'h0;
    end
    else
    begin
      st_q <= st_d;
      settle_q <= settle_d;
    end
  end

  // ****************************************************
  // Debug start words
  // ****************************************************

  logic [15:0] dkey_q; // Debug start key
  logic [15:0] dkey_d;
  logic [15:0] dsel_q; // Debug start selection
  logic [15:0] dsel_d;
  logic wr_dkey;
  logic wr_dsel;
  logic store_go;
  logic pins_q; // Verdict came from straps
  logic [1:0] strap_q; // Straps seen at evaluation

  assign wr_dkey = reg_wr && (reg_addr == BMS_DKEY_ADDR);
  assign wr_dsel = reg_wr && (reg_addr == BMS_DSEL_ADDR);
  // Record only on a pin-driven start
  assign store_go = (st_q == ST_STORE) && pins_q;

  // Device record beats a debugger write in the same cycle
  assign dkey_d = store_go ? BMS_KEY_VALID :
                  wr_dkey ? reg_wdata : dkey_q;
  assign dsel_d = store_go ? {14'h0000, strap_q} :
                  wr_dsel ? reg_wdata : dsel_q;

  // Plain rst_b leaves these alone so a debug restart sees them
  always_ff @(posedge clk)
  begin
    if (!por_b)
    begin
      dkey_q <= BMS_WORD_RST;
      dsel_q <= BMS_WORD_RST;
    end
    else
    begin
      dkey_q <= dkey_d;
      dsel_q <= dsel_d;
    end
  end

  // ****************************************************
  // Mode decode and capture
  // ****************************************************

  bms_mode_t dec_mode; // Combinational verdict
  bms_mode_t mode_q; // Captured verdict

  bms_decode u_dec (
    .dbg(dbg_s),
    .strap(strap_s),
    .dkey(dkey_q),
    .dsel(dsel_q),
    .pkey(programmed_boot_key),
    .psel(programmed_boot_selection),
    .mode(dec_mode)
  );

  // Sampled exactly once, at evaluation
  always_ff @(posedge clk)
  begin
    if (!sys_rst_b)
    begin
      mode_q <= BMS_WAIT;
      pins_q <= 1'b0;
      strap_q <= 2'h0;
    end
    else if (st_q == ST_EVAL)
    begin
      mode_q <= dec_mode;
      pins_q <= !dbg_s;
      strap_q <= strap_s;
    end
  end

  // ****************************************************
  // Outcome flags
  // ****************************************************

  logic done_q;
  logic jump_en_q;
  logic [21:0] jump_addr_q;
  logic [21:0] jump_addr_d;
  logic uart_q;
  logic wait_q;
  logic [6:0] i2c_q;
  logic [6:0] i2c_d;
  logic emu_q;

  // Fixed targets for the two jump modes
  assign jump_addr_d = (mode_q == BMS_RAM) ? BMS_RAM_JUMP :
                       (mode_q == BMS_FLASH) ? BMS_FLASH_JUMP :
                       BMS_NO_JUMP;
  // Serial memory address only matters for the I2C loader
  assign i2c_d = (mode_q == BMS_I2C) ? BMS_I2C_DEV : BMS_I2C_NONE;

  // Flags set together with done and then frozen
  always_ff @(posedge clk)
  begin
    if (!sys_rst_b)
    begin
      done_q <= 1'b0;
      jump_en_q <= 1'b0;
      jump_addr_q <= BMS_NO_JUMP;
      uart_q <= 1'b0;
      wait_q <= 1'b0;
      i2c_q <= BMS_I2C_NONE;
    end
    else if (st_q == ST_STORE)
    begin
      done_q <= 1'b1;
      jump_en_q <= (mode_q == BMS_RAM) || (mode_q == BMS_FLASH);
      jump_addr_q <= jump_addr_d;
      uart_q <= (mode_q == BMS_UART);
      wait_q <= (mode_q == BMS_WAIT);
      i2c_q <= i2c_d;
    end
  end

  // Emulator presence, for software polling in wait
  always_ff @(posedge clk)
  begin
    if (!sys_rst_b)
      emu_q <= 1'b0;
    else
      emu_q <= dbg_s;
  end

  // ****************************************************
  // Register read port
  // ****************************************************

  logic [15:0] stat_w;
  logic [15:0] rsel_w;
  logic [15:0] rdata_q;

  assign stat_w = (16'(mode_q) << BMS_ST_MODE_POS) |
                  (16'(done_q) << BMS_ST_DONE_POS) |
                  (16'(pins_q) << BMS_ST_PINS_POS) |
                  (16'(emu_q) << BMS_ST_EMU_POS);

  // Unmapped offsets read as zero
  assign rsel_w = (reg_addr == BMS_DKEY_ADDR) ? dkey_q :
                  (reg_addr == BMS_DSEL_ADDR) ? dsel_q :
                  (reg_addr == BMS_PKEY_ADDR) ? programmed_boot_key :
                  (reg_addr == BMS_PSEL_ADDR) ? programmed_boot_selection :
                  (reg_addr == BMS_STAT_ADDR) ? stat_w : 16'h0000;

  // Data valid for one cycle after the strobe only
  always_ff @(posedge clk)
  begin
    if (!sys_rst_b)
      rdata_q <= 16'h0000;
    else
      rdata_q <= reg_rd ? rsel_w : 16'h0000;
  end

  // ****************************************************
  // Outputs
  // ****************************************************

  assign reg_rdata = rdata_q;
  assign boot_mode = mode_q;
  assign boot_done = done_q;
  assign boot_from_pins = pins_q;
  assign jump_en = jump_en_q;
  assign jump_addr = jump_addr_q;
  assign uart_wait = uart_q;
  // Holding stops nothing by itself; a debugger reset ends it
  assign wait_hold = wait_q;
  assign i2c_dev_addr = i2c_q;
  assign emu_attached = emu_q;

  // ****************************************************
  // Assertions
  // ****************************************************

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!sys_rst_b);

  property p_pin_uart;
    (st_q == ST_EVAL && !dbg_s && strap_s == BMS_STRAP_UART) |=> (mode_q == BMS_UART);
  endproperty
  a_pin_uart: assert property (p_pin_uart) else $error("strap 01 did not pick serial load");

  property p_pin_record;
    (st_q == ST_EVAL && !dbg_s) |=> ##1
      (dkey_q == BMS_KEY_VALID && dsel_q == {14'h0000, $past(strap_s, 2)});
  endproperty
  a_pin_record: assert property (p_pin_record) else $error("pin start not recorded");

  property p_bad_key;
    (st_q == ST_EVAL && dbg_s && dkey_q != BMS_KEY_VALID) |=> (mode_q == BMS_WAIT);
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("bad debug key did not wait");

  property p_ram_jump;
    (st_q == ST_EVAL && dbg_s && dkey_q == BMS_KEY_VALID && dsel_q == BMS_DSEL_RAM) |=> ##1
      (jump_en && jump_addr == BMS_RAM_JUMP && boot_done);
  endproperty
  a_ram_jump: assert property (p_ram_jump) else $error("RAM jump target wrong");

  property p_hold;
    done_q |=> (done_q && $stable(mode_q) && $stable(jump_addr_q));
  endproperty
  a_hold: assert property (p_hold) else $error("mode changed after decision");

  property p_prog_fallback;
    (st_q == ST_EVAL && !dbg_s && strap_s == BMS_STRAP_CHOICE &&
     programmed_boot_key != BMS_KEY_VALID) |=> (mode_q == BMS_FLASH);
  endproperty
  a_prog_fallback: assert property (p_prog_fallback) else $error("bad programmed key not flash");

  property p_flash;
    (done_q && mode_q == BMS_FLASH) |-> (jump_en && jump_addr == BMS_FLASH_JUMP);
  endproperty
  a_flash: assert property (p_flash) else $error("flash jump target wrong");

  property p_i2c;
    (done_q && mode_q == BMS_I2C) |-> (i2c_dev_addr == BMS_I2C_DEV);
  endproperty
  a_i2c: assert property (p_i2c) else $error("I2C device address wrong");

  property p_wait;
    (st_q == ST_STORE && mode_q == BMS_WAIT) |=> (wait_hold && boot_done && !jump_en);
  endproperty
  a_wait: assert property (p_wait) else $error("wait mode not holding");

endmodule

`default_nettype wire

// >>> rtl/bms_pkg.sv
package bms_pkg;

  // ****************************************************
  // Bus geometry
  // ****************************************************
  localparam int BMS_AW = 22;
  localparam int BMS_DW = 16;

  // ****************************************************
  // Register offsets
  // ****************************************************
  localparam logic [21:0] BMS_DKEY_ADDR = 22'h000D00; // Debug start key word
  localparam logic [21:0] BMS_DSEL_ADDR = 22'h000D01; // Debug start selection word
  localparam logic [21:0] BMS_PKEY_ADDR = 22'h3D7BFE; // Programmed boot key
  localparam logic [21:0] BMS_PSEL_ADDR = 22'h3D7BFF; // Programmed boot selection
  localparam logic [21:0] BMS_STAT_ADDR = 22'h000D10; // Outcome status word

  // ****************************************************
  // Reset values and magic numbers
  // ****************************************************
  localparam logic [15:0] BMS_WORD_RST = 16'h0000;
  localparam logic [15:0] BMS_KEY_VALID = 16'h55AA;
  localparam logic [21:0] BMS_RAM_JUMP = 22'h000000;
  localparam logic [21:0] BMS_FLASH_JUMP = 22'h3F7FF6;
  localparam logic [21:0] BMS_NO_JUMP = 22'h000000;
  localparam logic [6:0] BMS_I2C_DEV = 7'h50;
  localparam logic [6:0] BMS_I2C_NONE = 7'h00;

  // ****************************************************
  // Strap codes (high pin, low pin)
  // ****************************************************
  localparam logic [1:0] BMS_STRAP_PAR = 2'h0;
  localparam logic [1:0] BMS_STRAP_UART = 2'h1;
  localparam logic [1:0] BMS_STRAP_WAIT = 2'h2;
  localparam logic [1:0] BMS_STRAP_CHOICE = 2'h3;

  // ****************************************************
  // Debug start selection codes
  // ****************************************************
  localparam logic [15:0] BMS_DSEL_PAR = 16'h0000;
  localparam logic [15:0] BMS_DSEL_UART = 16'h0001;
  localparam logic [15:0] BMS_DSEL_WAIT = 16'h0002;
  localparam logic [15:0] BMS_DSEL_CHOICE = 16'h0003;
  localparam logic [15:0] BMS_DSEL_SPI = 16'h0004;
  localparam logic [15:0] BMS_DSEL_I2C = 16'h0005;
  localparam logic [15:0] BMS_DSEL_OTP = 16'h0006;
  localparam logic [15:0] BMS_DSEL_RAM = 16'h000A;
  localparam logic [15:0] BMS_DSEL_FLASH = 16'h000B;

  // ****************************************************
  // Programmed selection codes
  // ****************************************************
  localparam logic [15:0] BMS_PSEL_UART = 16'h0001;
  localparam logic [15:0] BMS_PSEL_SPI = 16'h0004;
  localparam logic [15:0] BMS_PSEL_I2C = 16'h0005;
  localparam logic [15:0] BMS_PSEL_OTP = 16'h0006;
  localparam logic [15:0] BMS_PSEL_CAN = 16'h0007;

  // ****************************************************
  // Timing and status layout
  // ****************************************************
  localparam logic [1:0] BMS_SETTLE_CYC = 2'h2; // Synchroniser depth
  localparam int BMS_ST_MODE_POS = 0;
  localparam int BMS_ST_DONE_POS = 4;
  localparam int BMS_ST_PINS_POS = 5;
  localparam int BMS_ST_EMU_POS = 6;

  // Resolved start modes
  typedef enum logic [3:0] {
    BMS_PARALLEL, BMS_UART, BMS_WAIT, BMS_SPI, BMS_I2C,
    BMS_OTP, BMS_RAM, BMS_FLASH, BMS_CAN
  } bms_mode_t;

endpackage

// >>> rtl/bms_sync2.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************
// Two-flop synchroniser for pin levels
// ****************************************************
module bms_sync2 #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Asynchronous levels in, safe levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q; // First stage, read only by the second

  // Both stages clear to a constant on reset
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

`default_nettype wire

// >>> rtl/bms_decode.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************
// Pure decode of pins and stored words to a mode
// ****************************************************
module bms_decode
  import bms_pkg::*;
(
  // Sampled pins
  input wire logic dbg,
  input wire logic [1:0] strap,
  // Stored words
  input wire logic [15:0] dkey,
  input wire logic [15:0] dsel,
  input wire logic [15:0] pkey,
  input wire logic [15:0] psel,
  // Result
  output bms_pkg::bms_mode_t mode
);

  // Programmable choice; any odd word lands in flash
  function automatic bms_mode_t prog_mode(input logic [15:0] k, input logic [15:0] s);
    if (k != BMS_KEY_VALID) return BMS_FLASH;
    unique case (s)
      BMS_PSEL_UART: return BMS_UART;
      BMS_PSEL_SPI: return BMS_SPI;
      BMS_PSEL_I2C: return BMS_I2C;
      BMS_PSEL_OTP: return BMS_OTP;
      BMS_PSEL_CAN: return BMS_CAN;
      default: return BMS_FLASH;
    endcase
  endfunction

  // Debug start words; bad key or code falls to wait
  function automatic bms_mode_t dbg_mode(input logic [15:0] k, input logic [15:0] s);
    if (k != BMS_KEY_VALID) return BMS_WAIT;
    unique case (s)
      BMS_DSEL_PAR: return BMS_PARALLEL;
      BMS_DSEL_UART: return BMS_UART;
      BMS_DSEL_WAIT: return BMS_WAIT;
      BMS_DSEL_CHOICE: return prog_mode(pkey, psel);
      BMS_DSEL_SPI: return BMS_SPI;
      BMS_DSEL_I2C: return BMS_I2C;
      BMS_DSEL_OTP: return BMS_OTP;
      BMS_DSEL_RAM: return BMS_RAM;
      BMS_DSEL_FLASH: return BMS_FLASH;
      default: return BMS_WAIT;
    endcase
  endfunction

  // Pin path when the debug line is low, else stored words
  wire bms_mode_t pin_mode = (strap == BMS_STRAP_PAR) ? BMS_PARALLEL :
                             (strap == BMS_STRAP_UART) ? BMS_UART :
                             (strap == BMS_STRAP_WAIT) ? BMS_WAIT :
                             prog_mode(pkey, psel);
  assign mode = dbg ? dbg_mode(dkey, dsel) : pin_mode;

endmodule

`default_nettype wire

// >>> sim/bms_partner.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************
// Strap pins and debug pod at the far side
// ****************************************************
module bms_partner (
  // Clock
  input wire logic clk,
  // Requests from the bench
  input wire logic [1:0] want_strap,
  input wire logic want_attach,
  // Pins toward the device
  output logic strap_pin_low,
  output logic strap_pin_high,
  output logic debug_reset_line
);
  // Pins follow a request one edge late, like a slow pod
  // Unknown before the first edge; the device is held in reset then
  always @(posedge clk)
  begin
    strap_pin_high <= want_strap[1];
    strap_pin_low <= want_strap[0];
    debug_reset_line <= want_attach;
  end
endmodule
`default_nettype wire

// >>> sim/bms_selector_tb.sv
`timescale 1ns/1ps
`default_nettype none

module bms_selector_tb;
  import bms_pkg::*;
  // ****************************************************
  // Stimulus and observed signals
  // ****************************************************
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic por_b = 1'b0;
  logic [21:0] reg_addr = 22'h000000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] pkey = 16'h0000; // Unprogrammed words
  logic [15:0] psel = 16'h0000;
  logic [1:0] want_strap = 2'h0;
  logic want_attach = 1'b0;
  wire logic s_lo, s_hi, dbg;
  wire logic [15:0] reg_rdata;
  bms_mode_t boot_mode;
  wire logic boot_done, boot_from_pins, jump_en, uart_wait, wait_hold, emu_attached;
  wire logic [21:0] jump_addr;
  wire logic [6:0] i2c_dev_addr;
  int err_count = 0;
  int samples_checked = 0;
  logic [15:0] dk_m = 16'h0000; // Model of the debug words
  logic [15:0] ds_m = 16'h0000;
  bms_mode_t last_m;

  // 100 MHz clock
  initial forever #5 clk = ~clk;

  bms_partner bms_partner_i (.clk(clk), .want_strap(want_strap), .want_attach(want_attach),
    .strap_pin_low(s_lo), .strap_pin_high(s_hi), .debug_reset_line(dbg));

  bms_selector bms_selector_i (.clk(clk), .rst_b(rst_b), .por_b(por_b), .strap_pin_low(s_lo),
    .strap_pin_high(s_hi), .debug_reset_line(dbg), .programmed_boot_key(pkey),
    .programmed_boot_selection(psel), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .boot_mode(boot_mode), .boot_done(boot_done),
    .boot_from_pins(boot_from_pins), .jump_en(jump_en), .jump_addr(jump_addr), .uart_wait(uart_wait),
    .wait_hold(wait_hold), .i2c_dev_addr(i2c_dev_addr), .emu_attached(emu_attached));

  // ****************************************************
  // Expectations
  // ****************************************************
  // Programmed choice; blank words fall to flash
  function automatic bms_mode_t pmode(input logic [15:0] k, input logic [15:0] s);
    if (k !== BMS_KEY_VALID) return BMS_FLASH;
    case (s)
      BMS_PSEL_UART: return BMS_UART;
      BMS_PSEL_SPI: return BMS_SPI;
      BMS_PSEL_I2C: return BMS_I2C;
      BMS_PSEL_OTP: return BMS_OTP;
      BMS_PSEL_CAN: return BMS_CAN;
      default: return BMS_FLASH;
    endcase
  endfunction

  // Full selection from pins and stored words
  function automatic bms_mode_t emode(input logic d, input logic [1:0] s);
    if (!d)
    begin
      case (s)
        BMS_STRAP_PAR: return BMS_PARALLEL;
        BMS_STRAP_UART: return BMS_UART;
        BMS_STRAP_WAIT: return BMS_WAIT;
        default: return pmode(pkey, psel);
      endcase
    end
    if (dk_m !== BMS_KEY_VALID) return BMS_WAIT;
    case (ds_m)
      BMS_DSEL_PAR: return BMS_PARALLEL;
      BMS_DSEL_UART: return BMS_UART;
      BMS_DSEL_WAIT: return BMS_WAIT;
      BMS_DSEL_CHOICE: return pmode(pkey, psel);
      BMS_DSEL_SPI: return BMS_SPI;
      BMS_DSEL_I2C: return BMS_I2C;
      BMS_DSEL_OTP: return BMS_OTP;
      BMS_DSEL_RAM: return BMS_RAM;
      BMS_DSEL_FLASH: return BMS_FLASH;
      default: return BMS_WAIT;
    endcase
  endfunction

  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic complete_run;
    $display("Checks %0d, errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write; the model tracks the debug words
  task automatic wr(input logic [21:0] a, input logic [15:0] dat);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dat;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == BMS_DKEY_ADDR) dk_m = dat;
    if (a == BMS_DSEL_ADDR) ds_m = dat;
  endtask

  // One-cycle read; data stands only in the next cycle
  task automatic rd(input logic [21:0] a, output logic [15:0] dat);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 dat = reg_rdata;
  endtask

  // Every outcome port but boot_done, and the status word, against one mode
  task automatic outcome(input bms_mode_t m, input logic p, input logic d);
    logic [15:0] v;
    chk(32'(boot_mode), 32'(m));
    chk(32'(boot_from_pins), 32'(p));
    chk(32'(jump_en), 32'(m == BMS_RAM || m == BMS_FLASH));
    chk(32'(jump_addr), 32'(m == BMS_FLASH ? BMS_FLASH_JUMP : BMS_RAM_JUMP));
    chk(32'(uart_wait), 32'(m == BMS_UART));
    chk(32'(wait_hold), 32'(m == BMS_WAIT));
    chk(32'(i2c_dev_addr), 32'(m == BMS_I2C ? BMS_I2C_DEV : BMS_I2C_NONE));
    chk(32'(emu_attached), 32'(d));
    rd(BMS_STAT_ADDR, v);
    chk(32'(v), {16'h0, 9'h0, d, p, 1'b1, 4'(m)});
  endtask

  // Reset (power-on if pw) with given pins, then check the start
  task automatic boot(input logic pw, input logic [1:0] s, input logic d);
    int n;
    logic [15:0] v;
    @(posedge clk);
    want_strap <= s;
    want_attach <= d;
    rst_b <= 1'b0;
    por_b <= ~pw;
    repeat (4) @(posedge clk);
    chk(32'(boot_done), 32'h0);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    if (pw)
    begin
      dk_m = 16'h0000;
      ds_m = 16'h0000;
    end
    n = 0;
    while (boot_done !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 20)
    begin
      err_count++;
      complete_run();
    end
    #1;
    last_m = emode(d, s);
    outcome(last_m, !d, d);
    if (!d)
    begin
      dk_m = BMS_KEY_VALID;
      ds_m = {14'h0, s};
      rd(BMS_DKEY_ADDR, v);
      chk(32'(v), 32'(dk_m));
      rd(BMS_DSEL_ADDR, v);
      chk(32'(v), 32'(ds_m));
    end
  endtask

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial
  begin : main
    logic [15:0] v;
    logic d;
    void'($urandom(32'hf9e15045));
    repeat (16) @(posedge clk);
    // Every strap code, unprogrammed words
    for (int s = 0; s < 4; s++) boot(1'b1, 2'(s), 1'b0);
    // Programmed table, then a bad key
    pkey <= BMS_KEY_VALID;
    for (int i = 0; i < 12; i++)
    begin
      psel <= 16'(i);
      boot(1'b0, 2'h3, 1'b0);
    end
    pkey <= 16'h55AB;
    boot(1'b0, 2'h3, 1'b0);
    // Serial start alone, then debugger reset keeps it
    boot(1'b1, 2'h1, 1'b0);
    boot(1'b0, 2'h2, 1'b1);
    // Debugger rewrites the selection before each reset
    pkey <= BMS_KEY_VALID;
    psel <= BMS_PSEL_SPI;
    for (int i = 0; i < 16; i++)
    begin
      wr(BMS_DSEL_ADDR, 16'(i));
      boot(1'b0, 2'($urandom), 1'b1);
    end
    wr(BMS_DKEY_ADDR, 16'h1234);
    wr(BMS_DSEL_ADDR, BMS_DSEL_UART);
    boot(1'b0, 2'h1, 1'b1);
    // Stored selection survives resets until power cycle
    wr(BMS_DKEY_ADDR, BMS_KEY_VALID);
    wr(BMS_DSEL_ADDR, BMS_DSEL_RAM);
    rd(BMS_DSEL_ADDR, v);
    chk(32'(v), 32'(BMS_DSEL_RAM));
    boot(1'b0, 2'h0, 1'b1);
    boot(1'b0, 2'h3, 1'b1);
    boot(1'b1, 2'h2, 1'b0);
    // Late changes are ignored until the next reset
    want_strap <= 2'h1;
    psel <= BMS_PSEL_CAN;
    wr(BMS_DSEL_ADDR, BMS_DSEL_FLASH);
    repeat (6) @(posedge clk);
    // Look off the edge, where the outputs are settled
    #1;
    outcome(last_m, 1'b1, 1'b0);
    // Read-only and unmapped places
    wr(BMS_PKEY_ADDR, 16'h1111);
    rd(BMS_PKEY_ADDR, v);
    chk(32'(v), 32'(pkey));
    rd(BMS_PSEL_ADDR, v);
    chk(32'(v), 32'(psel));
    rd(22'h000D05, v);
    chk(32'(v), 32'h0);
    // Random starts from both sides
    for (int i = 0; i < 40; i++)
    begin
      d = 1'($urandom);
      pkey <= ($urandom % 2) ? BMS_KEY_VALID : 16'($urandom);
      psel <= 16'($urandom % 9);
      if (d)
      begin
        wr(BMS_DKEY_ADDR, ($urandom % 4) ? BMS_KEY_VALID : 16'($urandom));
        wr(BMS_DSEL_ADDR, 16'($urandom % 16));
      end
      boot(d ? 1'b0 : 1'($urandom), 2'($urandom), d);
    end
    complete_run();
  end
endmodule
`default_nettype wire
